// ---- asf_trim_field_defs.svh ----
// Constants for the angle sensor trim, field alarm and filter window block
`ifndef ASF_TRIM_FIELD_DEFS_SVH
`define ASF_TRIM_FIELD_DEFS_SVH
// Register addresses (5-bit)
`define ASF_ADDR_BIAS_TRIM      5'h02
`define ASF_ADDR_TRIM_ENABLE    5'h03
`define ASF_ADDR_THRESHOLD      5'h06
`define ASF_ADDR_FILTER_WINDOW  5'h0e
`define ASF_ADDR_ALARM_STATUS   5'h1b
// Reset values
`define ASF_RST_BIAS_TRIM       8'h00
`define ASF_RST_TRIM_ENABLE     8'h00
`define ASF_RST_THRESHOLD       8'h1c
`define ASF_RST_FILTER_WINDOW   8'h77
`define ASF_RST_TAU_INDEX       4'h4
// Field positions
`define ASF_BIT_X_EN            0
`define ASF_BIT_Y_EN            1
`define ASF_LOW_CODE_MSB        7
`define ASF_LOW_CODE_LSB        5
`define ASF_HIGH_CODE_MSB       4
`define ASF_HIGH_CODE_LSB       2
`define ASF_THRESHOLD_MASK      8'hfc
`define ASF_TRIM_ENABLE_MASK    8'h03
`define ASF_BIT_HIGH_ALARM      7
`define ASF_BIT_LOW_ALARM       6
// Frame commands and length
`define ASF_CMD_READ            3'h2
`define ASF_CMD_WRITE           3'h4
`define ASF_FRAME_BITS          5'h10
// Field trip levels in mT, rising edge; falling level is rising minus hysteresis
`define ASF_FIELD_HYS_MT        8'h06
`define ASF_RISE_TABLE          {8'h7e, 8'h70, 8'h62, 8'h54, 8'h46, 8'h38, 8'h29, 8'h1a}
// Filter window codes: first code, step, number of codes
`define ASF_FW_FIRST            8'h33
`define ASF_FW_STEP             8'h11
`define ASF_FW_COUNT            9
`endif

// ---- asf_trim_field_pkg.sv ----
// Types shared by the angle sensor trim and field alarm block
package asf_trim_field_pkg;
   // One 16-bit host frame, most significant bit first on the wire
   typedef struct packed {
      logic [2:0] cmd;
      logic [4:0] addr;
      logic [7:0] data;
   } asf_frame_t;

   // Trim outputs toward the Hall bias stage
   typedef struct packed {
      logic [7:0] x_reduction;
      logic [7:0] y_reduction;
   } asf_bias_t;

   typedef enum logic {ASF_IDLE, ASF_SHIFT} asf_link_state_t;
endpackage

// ---- asf_trim_field.sv ----
// Trim, field alarm and filter window logic with its serial register port
//
// Contract
// - Trim amount 0..255 scales bias reduction
// - Trim reaches an axis only when enabled
// - Both enabled gives equal reduction
// - Alarms flag field below low, above high
// - Six mT hysteresis on both alarms
// - Two 3-bit threshold codes in register 6
// - Code selects rising and falling trip levels
// - Low and high thresholds evaluated independently
// - Flags at status bits 7, 6 and pins
// - Reply comes in the following frame
// - Filter code selects doubling time constant
`include "asf_trim_field_defs.svh"
module asf_trim_field (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic                      spi_cs_n,
   input  wire logic                      spi_sclk,
   input  wire logic                      spi_mosi,
   output logic                           spi_miso,
   output logic                           spi_miso_oe,
   input  wire logic [7:0]                field_strength_mt,
   input  wire logic                      field_sample_valid,
   output logic                           high_field_alarm,
   output logic                           low_field_alarm,
   output asf_trim_field_pkg::asf_bias_t  bias_trim,
   output logic [3:0]                     filter_tau_index,
   output logic [7:0]                     filter_window_code
);
   // Synchronisers for the host pins
   logic [2:0]                          sclk_sync_r;
   logic [2:0]                          cs_sync_r;
   logic [1:0]                          mosi_sync_r;
   // Link state
   asf_trim_field_pkg::asf_link_state_t state_r;
   logic [15:0]                         rx_shift_r;
   logic [15:0]                         tx_shift_r;
   logic [15:0]                         reply_r;
   logic [4:0]                          bit_cnt_r;
   logic                                miso_r;
   logic                                miso_oe_r;
   // Configuration registers
   logic [7:0]                          bias_trim_amount_r;
   logic [7:0]                          trim_enable_r;
   logic [7:0]                          field_threshold_config_r;
   logic [7:0]                          filter_window_code_r;
   logic [3:0]                          tau_index_r;
   // Outputs
   logic                                high_alarm_r;
   logic                                low_alarm_r;
   asf_trim_field_pkg::asf_bias_t       bias_r;

   // Edge and frame detection on synchronised pins
   wire                                 sclk_rise   = sclk_sync_r[1] & ~sclk_sync_r[2];
   wire                                 sclk_fall   = ~sclk_sync_r[1] & sclk_sync_r[2];
   wire                                 cs_active   = ~cs_sync_r[1];
   wire                                 cs_start    = ~cs_sync_r[1] & cs_sync_r[2];
   wire                                 cs_end      = cs_sync_r[1] & ~cs_sync_r[2];
   wire                                 frame_done  = cs_end & (bit_cnt_r == `ASF_FRAME_BITS);
   asf_trim_field_pkg::asf_frame_t      frame;
   assign frame = rx_shift_r;

   // Field names of the configuration
   wire                                 x_axis_trim_enable = trim_enable_r[`ASF_BIT_X_EN];
   wire                                 y_axis_trim_enable = trim_enable_r[`ASF_BIT_Y_EN];
   wire [2:0] low_field_threshold_code  = field_threshold_config_r[`ASF_LOW_CODE_MSB:`ASF_LOW_CODE_LSB];
   wire [2:0] high_field_threshold_code = field_threshold_config_r[`ASF_HIGH_CODE_MSB:`ASF_HIGH_CODE_LSB];

   // Trip levels from the threshold codes
   wire [63:0]                          rise_table = `ASF_RISE_TABLE;
   wire [7:0] high_rise = rise_table[{high_field_threshold_code, 3'h0} +: 8];
   wire [7:0] high_fall = high_rise - `ASF_FIELD_HYS_MT;
   wire [7:0] low_rise  = rise_table[{low_field_threshold_code, 3'h0} +: 8];
   wire [7:0] low_fall  = low_rise - `ASF_FIELD_HYS_MT;

   // Next alarm states; each flag has its own band
   wire high_alarm_nxt = (field_strength_mt > high_rise) ? 1'b1 :
                         (field_strength_mt < high_fall) ? 1'b0 : high_alarm_r;
   wire low_alarm_nxt  = (field_strength_mt < low_fall) ? 1'b1 :
                         (field_strength_mt > low_rise) ? 1'b0 : low_alarm_r;

   // Status word as seen by the host
   wire [7:0] field_alarm_status;
   assign field_alarm_status = {high_alarm_r, low_alarm_r, 6'h00};

   // Read and write decode
   wire       wr_frame   = frame_done & (frame.cmd == `ASF_CMD_WRITE);
   wire       rd_frame   = frame_done & (frame.cmd == `ASF_CMD_READ);
   wire       wr_trim    = wr_frame & (frame.addr == `ASF_ADDR_BIAS_TRIM);
   wire       wr_enable  = wr_frame & (frame.addr == `ASF_ADDR_TRIM_ENABLE);
   wire       wr_thresh  = wr_frame & (frame.addr == `ASF_ADDR_THRESHOLD);
   wire       wr_filter  = wr_frame & (frame.addr == `ASF_ADDR_FILTER_WINDOW);

   // Register value that the current frame's address names, after any write
   wire [7:0] trim_nxt   = wr_trim ? frame.data : bias_trim_amount_r;
   wire [7:0] enable_nxt = wr_enable ? (frame.data & `ASF_TRIM_ENABLE_MASK) : trim_enable_r;
   wire [7:0] thresh_nxt = wr_thresh ? (frame.data & `ASF_THRESHOLD_MASK) : field_threshold_config_r;
   wire [7:0] filter_nxt = wr_filter ? frame.data : filter_window_code_r;
   wire [7:0] read_data  = (frame.addr == `ASF_ADDR_BIAS_TRIM)     ? trim_nxt   :
                           (frame.addr == `ASF_ADDR_TRIM_ENABLE)   ? enable_nxt :
                           (frame.addr == `ASF_ADDR_THRESHOLD)     ? thresh_nxt :
                           (frame.addr == `ASF_ADDR_FILTER_WINDOW) ? filter_nxt :
                           (frame.addr == `ASF_ADDR_ALARM_STATUS)  ? field_alarm_status : 8'h00;
   wire [15:0] reply_nxt = (rd_frame | wr_frame) ? {read_data, 8'h00} : 16'h0000;

   // Filter window code to time constant index, one comparator per legal code
   logic [`ASF_FW_COUNT-1:0] fw_hit;
   genvar gi;
   generate
      for (gi = 0; gi < `ASF_FW_COUNT; gi++) begin : g_fw
         localparam logic [7:0] FW_CODE = 8'(`ASF_FW_FIRST + gi * `ASF_FW_STEP);
         assign fw_hit[gi] = (filter_window_code_r == FW_CODE);
      end
   endgenerate

   logic [3:0] tau_index_nxt;
   always_comb begin
      tau_index_nxt = tau_index_r;
      for (int i = 0; i < `ASF_FW_COUNT; i++) begin
         if (fw_hit[i]) begin
            tau_index_nxt = 4'(i);
         end
      end
   end

   // Pin synchronisers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sclk_sync_r <= 3'h0;
         cs_sync_r   <= 3'h7;
         mosi_sync_r <= 2'h0;
      end else begin
         sclk_sync_r <= {sclk_sync_r[1:0], spi_sclk};
         cs_sync_r   <= {cs_sync_r[1:0], spi_cs_n};
         mosi_sync_r <= {mosi_sync_r[0], spi_mosi};
      end
   end

   // Frame state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= asf_trim_field_pkg::ASF_IDLE;
      end else begin
         case (state_r)
            asf_trim_field_pkg::ASF_IDLE:  state_r <= cs_start ? asf_trim_field_pkg::ASF_SHIFT : state_r;
            asf_trim_field_pkg::ASF_SHIFT: state_r <= cs_end ? asf_trim_field_pkg::ASF_IDLE : state_r;
            default:                       state_r <= asf_trim_field_pkg::ASF_IDLE;
         endcase
      end
   end

   // Receive shifter, mode 0: sample on rising clock edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_shift_r <= 16'h0000;
         bit_cnt_r  <= 5'h00;
      end else if (cs_start) begin
         bit_cnt_r  <= 5'h00;
      end else if (cs_active && sclk_rise && state_r == asf_trim_field_pkg::ASF_SHIFT) begin
         rx_shift_r <= {rx_shift_r[14:0], mosi_sync_r[1]};
         bit_cnt_r  <= (bit_cnt_r == 5'h1f) ? bit_cnt_r : bit_cnt_r + 5'h01;
      end
   end

   // Transmit shifter: reply loaded at frame start, next bit on falling edge
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tx_shift_r <= 16'h0000;
         miso_r     <= 1'b0;
         miso_oe_r  <= 1'b0;
      end else if (cs_start) begin
         tx_shift_r <= {reply_r[14:0], 1'b0};
         miso_r     <= reply_r[15];
         miso_oe_r  <= 1'b1;
      end else if (cs_end) begin
         miso_oe_r  <= 1'b0;
      end else if (cs_active && sclk_fall) begin
         tx_shift_r <= {tx_shift_r[14:0], 1'b0};
         miso_r     <= tx_shift_r[15];
      end
   end

   // Reply for the next frame; short or unknown frames answer zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reply_r <= 16'h0000;
      end else if (cs_end) begin
         reply_r <= reply_nxt;
      end
   end

   // Configuration registers
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bias_trim_amount_r       <= `ASF_RST_BIAS_TRIM;
         trim_enable_r            <= `ASF_RST_TRIM_ENABLE;
         field_threshold_config_r <= `ASF_RST_THRESHOLD;
         filter_window_code_r     <= `ASF_RST_FILTER_WINDOW;
      end else begin
         bias_trim_amount_r       <= trim_nxt;
         trim_enable_r            <= enable_nxt;
         field_threshold_config_r <= thresh_nxt;
         filter_window_code_r     <= filter_nxt;
      end
   end

   // Time constant index; illegal codes keep the last legal setting
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tau_index_r <= `ASF_RST_TAU_INDEX;
      end else begin
         tau_index_r <= tau_index_nxt;
      end
   end

   // Bias reduction per axis, gated by its enable
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         bias_r <= '0;
      end else begin
         bias_r.x_reduction <= x_axis_trim_enable ? bias_trim_amount_r : 8'h00;
         bias_r.y_reduction <= y_axis_trim_enable ? bias_trim_amount_r : 8'h00;
      end
   end

   // Field alarms, updated on each new measurement
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         high_alarm_r <= 1'b0;
         low_alarm_r  <= 1'b0;
      end else if (field_sample_valid) begin
         high_alarm_r <= high_alarm_nxt;
         low_alarm_r  <= low_alarm_nxt;
      end
   end

   assign spi_miso           = miso_r;
   assign spi_miso_oe        = miso_oe_r;
   assign high_field_alarm   = high_alarm_r;
   assign low_field_alarm    = low_alarm_r;
   assign bias_trim          = bias_r;
   assign filter_tau_index   = tau_index_r;
   assign filter_window_code = filter_window_code_r;

   // Checks
   a_x_trim_gate: assert property (@(posedge clk) disable iff (sys_rst)
      ##1 bias_r.x_reduction == ($past(trim_enable_r[`ASF_BIT_X_EN]) ? $past(bias_trim_amount_r) : 8'h00))
      else $error("x bias reduction does not follow trim and enable");
   a_both_equal: assert property (@(posedge clk) disable iff (sys_rst)
      (x_axis_trim_enable && y_axis_trim_enable) ##1 (x_axis_trim_enable && y_axis_trim_enable)
      |-> bias_r.x_reduction == bias_r.y_reduction)
      else $error("both axes enabled but reductions differ");
   a_trim_scale: assert property (@(posedge clk) disable iff (sys_rst)
      trim_enable_r[`ASF_BIT_Y_EN] ##1 $stable(bias_trim_amount_r) |-> bias_r.y_reduction == bias_trim_amount_r)
      else $error("y reduction not equal to trim amount");
   a_high_set: assert property (@(posedge clk) disable iff (sys_rst)
      field_sample_valid && field_strength_mt > high_rise |=> high_alarm_r)
      else $error("high alarm not raised above rising level");
   a_high_clear: assert property (@(posedge clk) disable iff (sys_rst)
      field_sample_valid && field_strength_mt < high_rise - `ASF_FIELD_HYS_MT |=> !high_alarm_r)
      else $error("high alarm not cleared below falling level");
   a_low_set: assert property (@(posedge clk) disable iff (sys_rst)
      field_sample_valid && field_strength_mt < low_rise - `ASF_FIELD_HYS_MT |=> low_alarm_r)
      else $error("low alarm not raised below falling level");
   a_low_hold: assert property (@(posedge clk) disable iff (sys_rst)
      field_sample_valid && field_strength_mt >= low_fall && field_strength_mt <= low_rise |=> $stable(low_alarm_r))
      else $error("low alarm moved inside hysteresis band");
   a_alarm_idle: assert property (@(posedge clk) disable iff (sys_rst)
      !field_sample_valid |=> $stable(high_alarm_r) && $stable(low_alarm_r))
      else $error("alarm changed without a field sample");
   a_status_reply: assert property (@(posedge clk) disable iff (sys_rst)
      rd_frame && frame.addr == `ASF_ADDR_ALARM_STATUS |=> reply_r == {$past(high_alarm_r), $past(low_alarm_r), 14'h0000})
      else $error("status reply does not carry both flags");
   a_fw_default: assert property (@(posedge clk) disable iff (sys_rst)
      filter_window_code_r == `ASF_RST_FILTER_WINDOW ##1 filter_window_code_r == `ASF_RST_FILTER_WINDOW
      |-> tau_index_r == `ASF_RST_TAU_INDEX)
      else $error("default filter code gives wrong time constant");
   c_status_read: cover property (@(posedge clk) rd_frame && frame.addr == `ASF_ADDR_ALARM_STATUS);
   c_thresh_write: cover property (@(posedge clk) wr_thresh);
   c_high_rise: cover property (@(posedge clk) !high_alarm_r ##1 high_alarm_r);
   c_low_rise: cover property (@(posedge clk) !low_alarm_r ##1 low_alarm_r);
endmodule // asf_trim_field

// ---- asf_host_model.sv ----
// Host side model of the sensor's serial register port
module asf_host_model (
   input  wire logic clk,
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_mosi,
   input  wire logic spi_miso,
   input  wire logic spi_miso_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   // Idle pins: select high, clock parked low, data at its pull-down level
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_mosi = 1'b0;
   end

   // Let n system clocks pass, then step off the edge
   task automatic clk_wait(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // One frame, MSB first; a reply bit read while the driver is off shows as unknown
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      clk_wait(1);
      spi_cs_n = 1'b0;
      rx = 16'h0000;
      for (int i = 15; i > 15 - nbits; i--) begin
         spi_mosi = tx[i];
         clk_wait(4);
         spi_sclk = 1'b1;
         rx = {rx[14:0], spi_miso_oe ? spi_miso : 1'bx};
         clk_wait(4);
         spi_sclk = 1'b0;
      end
      clk_wait(4);
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
      // Gap long enough for the block to decode the frame
      clk_wait(8);
   endtask
endmodule // asf_host_model

// ---- asf_trim_field_bench.sv ----
// Self-checking bench for the trim, field alarm and filter window block
`include "asf_trim_field_defs.svh"
module asf_trim_field_bench;
   timeunit 1ns;
   timeprecision 100ps;

   logic                          clk;
   logic                          sys_rst;
   logic                          spi_cs_n;
   logic                          spi_sclk;
   logic                          spi_mosi;
   logic                          spi_miso;
   logic                          spi_miso_oe;
   logic [7:0]                    field_strength_mt;
   logic                          field_sample_valid;
   logic                          high_field_alarm;
   logic                          low_field_alarm;
   asf_trim_field_pkg::asf_bias_t bias_trim;
   logic [3:0]                    filter_tau_index;
   logic [7:0]                    filter_window_code;
   int                            fails;
   int                            total_checks;
   int                            cycles;
   logic                          exp_h;
   logic                          exp_l;
   logic [2:0]                    hi_code;
   logic [2:0]                    lo_code;
   int                            rise_lvl [8] = '{26, 41, 56, 70, 84, 98, 112, 126};

   asf_trim_field asf_trim_field_i (
      .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
      .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .field_strength_mt(field_strength_mt), .field_sample_valid(field_sample_valid),
      .high_field_alarm(high_field_alarm), .low_field_alarm(low_field_alarm),
      .bias_trim(bias_trim), .filter_tau_index(filter_tau_index),
      .filter_window_code(filter_window_code)
   );

   asf_host_model asf_host_model_i (
      .clk(clk), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe)
   );

   // 10 MHz system clock
   initial clk = 1'b0;
   always #50 clk = ~clk;

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         fails++;
         summarize();
      end
   end

   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      logic [15:0] r;
      asf_host_model_i.xfer({`ASF_CMD_WRITE, a, d}, 16, r);
   endtask

   // Read request, then the reply in the following frame
   task automatic chk_reg(input logic [4:0] a, input logic [7:0] exp);
      logic [15:0] r;
      asf_host_model_i.xfer({`ASF_CMD_READ, a, 8'h00}, 16, r);
      asf_host_model_i.xfer(16'h0000, 16, r);
      chk("register reply", {exp, 8'h00}, r);
   endtask

   // Present one sample and advance the expected alarm state
   task automatic put_sample(input int f);
      field_strength_mt = 8'(f);
      field_sample_valid = 1'b1;
      if (f > rise_lvl[hi_code]) exp_h = 1'b1;
      else if (f < rise_lvl[hi_code] - 6) exp_h = 1'b0;
      if (f < rise_lvl[lo_code] - 6) exp_l = 1'b1;
      else if (f > rise_lvl[lo_code]) exp_l = 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic end_samples;
      field_sample_valid = 1'b0;
      @(posedge clk);
      #1;
      chk("high_field_alarm", exp_h, high_field_alarm);
      chk("low_field_alarm", exp_l, low_field_alarm);
   endtask

   // Main sequence
   initial begin
      logic [15:0] r;
      int rh;
      int rl;
      sys_rst = 1'b1;
      field_strength_mt = 8'h00;
      field_sample_valid = 1'b0;
      exp_h = 1'b0;
      exp_l = 1'b0;
      hi_code = 3'h7;
      lo_code = 3'h0;
      repeat (16) @(posedge clk);
      #1;
      sys_rst = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      // Values after reset
      chk("bias_trim", 16'h0000, bias_trim);
      chk("filter_tau_index", 16'h0004, filter_tau_index);
      chk("filter_window_code", 16'h0077, filter_window_code);
      chk_reg(`ASF_ADDR_BIAS_TRIM, 8'h00);
      chk_reg(`ASF_ADDR_TRIM_ENABLE, 8'h00);
      chk_reg(`ASF_ADDR_THRESHOLD, 8'h1c);
      chk_reg(`ASF_ADDR_FILTER_WINDOW, 8'h77);
      // Trim for a field ratio of two, every enable combination
      wr(`ASF_ADDR_BIAS_TRIM, 8'h81);
      for (int e = 0; e < 4; e++) begin
         wr(`ASF_ADDR_TRIM_ENABLE, {6'h3f, 2'(e)});
         chk("bias_trim", {e[0] ? 8'h81 : 8'h00, e[1] ? 8'h81 : 8'h00}, bias_trim);
      end
      chk_reg(`ASF_ADDR_TRIM_ENABLE, 8'h03);
      wr(`ASF_ADDR_BIAS_TRIM, 8'hff);
      chk("bias_trim", 16'hffff, bias_trim);
      // A short frame must not write
      asf_host_model_i.xfer({`ASF_CMD_WRITE, `ASF_ADDR_BIAS_TRIM, 8'h12}, 8, r);
      chk_reg(`ASF_ADDR_BIAS_TRIM, 8'hff);
      chk_reg(5'h1f, 8'h00);
      // Every filter window code, then one off the grid
      for (int k = 0; k < 9; k++) begin
         wr(`ASF_ADDR_FILTER_WINDOW, 8'(51 + 17 * k));
         chk("filter_tau_index", 16'(k), filter_tau_index);
         chk("filter_window_code", 16'(51 + 17 * k), filter_window_code);
      end
      wr(`ASF_ADDR_FILTER_WINDOW, 8'h34);
      chk("filter_tau_index", 16'h0008, filter_tau_index);
      // Each threshold code, low code mirrored against high code
      for (int c = 0; c < 8; c++) begin
         hi_code = 3'(c);
         lo_code = 3'(7 - c);
         rh = rise_lvl[hi_code];
         rl = rise_lvl[lo_code];
         wr(`ASF_ADDR_THRESHOLD, {lo_code, hi_code, 2'b11});
         chk_reg(`ASF_ADDR_THRESHOLD, {lo_code, hi_code, 2'b00});
         foreach (rise_lvl[j]) begin
            put_sample(j < 4 ? rh + 1 - (j == 1) - 6 * (j == 2) - 7 * (j == 3)
                             : rl - 7 + (j == 5) + 7 * (j == 6) + 8 * (j == 7));
            end_samples();
         end
         // Trip points approached from the cleared side must not trip
         put_sample(rh - 7);
         put_sample(rh);
         end_samples();
         put_sample(rl + 1);
         put_sample(rl - 6);
         end_samples();
         // Back to back samples, each one evaluated
         put_sample(rh + 1);
         put_sample(rl - 7);
         end_samples();
         chk_reg(`ASF_ADDR_ALARM_STATUS, {exp_h, exp_l, 6'h00});
      end
      // Status is read only
      wr(`ASF_ADDR_ALARM_STATUS, 8'h00);
      chk_reg(`ASF_ADDR_ALARM_STATUS, {exp_h, exp_l, 6'h00});
      // Reset in mid-run returns the settings to their defaults
      sys_rst = 1'b1;
      @(posedge clk);
      #1;
      sys_rst = 1'b0;
      exp_h = 1'b0;
      exp_l = 1'b0;
      repeat (4) @(posedge clk);
      #1;
      chk("bias_trim", 16'h0000, bias_trim);
      chk("high_field_alarm", exp_h, high_field_alarm);
      chk("low_field_alarm", exp_l, low_field_alarm);
      chk_reg(`ASF_ADDR_THRESHOLD, 8'h1c);
      summarize();
   end
endmodule // asf_trim_field_bench
